// ==== hw/fpa_defines.vh ====
// Purpose: Constants for the front panel annunciator.
// Assumes: 50 MHz CLK_I, Wishbone classic slave with 32-bit data.
// Notes: Offsets are byte addresses.
//
// Contract
// - Store in edit mode saves and applies setpoint
// - Successful store flashes a confirmation message
// - Idle over two minutes shows default, unless alarm/trip
// - Double store in monitor view selects default
// - Monitor page 2 never becomes the default
// - Store without access: unchanged, denied flash 2 s
// - Store acts only in edit or monitor mode
// - Run lit when commanded contactor confirms closed
// - Stop lit when both contactors off
// - Trip lights indicator and blocks motor starts
// - Aux relay follows trip indicator when configured
// - Trip cleared by front, rear or serial reset
// - Alarm indicator lit; aux follows when configured
// - Service lit on self-test failure
// - Monitor view has four ordered pages
// - Page key shows first line of next page
// - Page key on last page wraps to first
// - Power loss reverts default to phase currents
// - Edited setpoint unused until stored
// - Latched trip classes ignore front reset key
`ifndef FPA_DEFINES_VH
`define FPA_DEFINES_VH

`define FPA_CLK_NS 20
`define FPA_TICK_NS 1000000
`define FPA_IDLE_MS 120000
`define FPA_DENY_MS 2000
`define FPA_CONF_MS 1000

`define FPA_ADR_CTRL 8'h00
`define FPA_ADR_STATUS 8'h04
`define FPA_ADR_DEFAULT 8'h08
`define FPA_ADR_SP_SEL 8'h0C
`define FPA_ADR_SP_DATA 8'h10
`define FPA_ADR_EDIT 8'h14

`define FPA_CTRL_AUX_LO 0
`define FPA_CTRL_AUX_HI 1
`define FPA_CTRL_SER_RST 2
`define FPA_AUX_OFF 2'h0
`define FPA_AUX_TRIP 2'h1
`define FPA_AUX_ALARM 2'h2

`define FPA_PAGES 4
`define FPA_PAGE_STATUS 2'h1
`define FPA_DEF_PAGE_RST 2'h0
`define FPA_DEF_LINE_RST 3'h1

`define FPA_MSG_NORMAL 3'h0
`define FPA_MSG_STORED 3'h1
`define FPA_MSG_NEWDEF 3'h2
`define FPA_MSG_DENIED 3'h3
`define FPA_MSG_DEFAULT 3'h4

`endif

// ==== hw/fpa_sync.v ====
// Purpose: Two-stage synchroniser with rising-edge pulses for panel pins.
// Assumes: Inputs are asynchronous to CLK_I; key bounce handled outside.
// Notes: Edge pulses come from the second stage only.
`timescale 1ns/100ps
module fpa_sync #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] level_o,
    output wire [W-1:0] rise_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    reg [W-1:0] prev_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
            prev_r <= {W{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r;
endmodule

// ==== hw/fpa_top.v ====
// Purpose: Front panel logic: setpoint store, default message, indicators.
// Assumes: Keys, contactor status and fault inputs are pins; one clock.
// Notes: Setpoint memory is a register array standing in for non-volatile storage.
`timescale 1ns/100ps
`include "fpa_defines.vh"
module fpa_top #(
    parameter TICK_CYC = `FPA_TICK_NS / `FPA_CLK_NS,
    parameter IDLE_MS = `FPA_IDLE_MS,
    parameter DENY_MS = `FPA_DENY_MS,
    parameter CONF_MS = `FPA_CONF_MS,
    parameter LINES = 8,
    parameter SP_W = 8
) (
    input wire CLK_I,
    input wire RESET_I,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output reg ACK_O,
    input wire KEY_STORE_I,
    input wire KEY_PAGE_I,
    input wire KEY_LINE_UP_I,
    input wire KEY_LINE_DOWN_I,
    input wire KEY_VALUE_UP_I,
    input wire KEY_VALUE_DOWN_I,
    input wire KEY_RESET_I,
    input wire KEY_MONITOR_I,
    input wire KEY_SETTINGS_I,
    input wire ACCESS_I,
    input wire LOCKOUT_RESET_I,
    input wire CMD_A_I,
    input wire CMD_B_I,
    input wire STAT_A_I,
    input wire STAT_B_I,
    input wire TRIP_I,
    input wire TRIP_LATCHED_I,
    input wire ALARM_I,
    input wire SELFTEST_FAIL_I,
    output reg [2:0] DISP_MSG_O,
    output reg [1:0] DISP_PAGE_O,
    output reg [2:0] DISP_LINE_O,
    output reg DISP_SETTINGS_O,
    output reg RUN_LED_O,
    output reg STOP_LED_O,
    output reg TRIP_LED_O,
    output reg ALARM_LED_O,
    output reg SERVICE_LED_O,
    output reg AUX_OUTPUT_RELAY_O,
    output reg START_BLOCK_O
);
    localparam M_MON = 2'b01;
    localparam M_SET = 2'b10;
    localparam integer LAST_LINE_I = LINES - 1;
    localparam integer TICK_LAST_I = TICK_CYC - 1;
    localparam integer IDLE_LIM_I = IDLE_MS;
    localparam integer DENY_LEN_I = DENY_MS;
    localparam integer CONF_LEN_I = CONF_MS;
    localparam [2:0] LAST_LINE = LAST_LINE_I[2:0];
    localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
    localparam [16:0] IDLE_LIM = IDLE_LIM_I[16:0];
    localparam [16:0] DENY_LEN = DENY_LEN_I[16:0];
    localparam [16:0] CONF_LEN = CONF_LEN_I[16:0];

    wire [18:0] lvl;
    wire [18:0] rise;

    fpa_sync #(
        .W(19)
    ) u_sync (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .async_i({SELFTEST_FAIL_I, ALARM_I, TRIP_LATCHED_I, TRIP_I, STAT_B_I,
                  STAT_A_I, CMD_B_I, CMD_A_I, LOCKOUT_RESET_I, ACCESS_I,
                  KEY_SETTINGS_I, KEY_MONITOR_I, KEY_RESET_I, KEY_VALUE_DOWN_I,
                  KEY_VALUE_UP_I, KEY_LINE_DOWN_I, KEY_LINE_UP_I, KEY_PAGE_I,
                  KEY_STORE_I}),
        .level_o(lvl),
        .rise_o(rise)
    );

    wire k_store = rise[0];
    wire k_page = rise[1];
    wire k_lup = rise[2];
    wire k_ldn = rise[3];
    wire k_vup = rise[4];
    wire k_vdn = rise[5];
    wire k_rst = rise[6];
    wire k_mon = rise[7];
    wire k_set = rise[8];
    wire any_key = |rise[8:0];
    wire access = lvl[9];
    wire rear_rst = rise[10];
    wire cmd_a = lvl[11];
    wire cmd_b = lvl[12];
    wire stat_a = lvl[13];
    wire stat_b = lvl[14];
    wire trip_in = lvl[15];
    wire trip_hard_in = lvl[16];
    wire alarm = lvl[17];
    wire self_fail = lvl[18];

    reg [1:0] mode_r;
    reg [1:0] page_r;
    reg [2:0] line_r;
    reg [1:0] def_page_r;
    reg [2:0] def_line_r;
    reg [SP_W-1:0] sp_mem [0:31];
    reg [SP_W-1:0] edit_r;
    reg dirty_r;
    reg arm_r;
    reg [2:0] flash_msg_r;
    reg [16:0] flash_cnt_r;
    reg [16:0] idle_cnt_r;
    reg showing_def_r;
    reg [15:0] div_r;
    reg tick_r;
    reg trip_r;
    reg hard_r;
    reg [1:0] aux_mode_r;
    reg ser_rst_r;
    reg [4:0] sp_sel_r;
    integer i;

    wire [4:0] idx = {page_r, line_r};
    wire [SP_W-1:0] shown_sp = dirty_r ? edit_r : sp_mem[idx];
    wire in_set = mode_r == M_SET;
    wire in_mon = mode_r == M_MON;
    wire idle_over = idle_cnt_r > IDLE_LIM;

    function is_live;
        input [16:0] cnt;
        begin
            is_live = cnt != 17'h00000;
        end
    endfunction

    function [SP_W-1:0] next_sp;
        input [SP_W-1:0] val;
        input up;
        begin
            next_sp = up ? val + 1'b1 : val - 1'b1;
        end
    endfunction

    function [2:0] line_step;
        input [2:0] cur;
        input down;
        begin
            line_step = down ? cur + 3'h1 : cur - 3'h1;
        end
    endfunction

    // Fixed 1 ms tick runs independent of key activity; a key restarts the idle count, not the tick
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            div_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= div_r == TICK_LAST;
            div_r <= (div_r == TICK_LAST) ? 16'h0000 : div_r + 16'h0001;
        end
    end

    // Trip latch; a new trip in the clearing cycle wins over the clear
    wire front_clr = k_rst & ~hard_r;
    wire trip_clr = front_clr | rear_rst | ser_rst_r;
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            trip_r <= 1'b0;
            hard_r <= 1'b0;
        end else begin
            trip_r <= trip_in | (trip_r & ~trip_clr);
            hard_r <= (trip_in & trip_hard_in) | (hard_r & ~(rear_rst | ser_rst_r));
        end
    end

    // Front panel navigation, store key handling and message flashes
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            mode_r <= M_MON;
            page_r <= 2'h0;
            line_r <= 3'h0;
            def_page_r <= `FPA_DEF_PAGE_RST;
            def_line_r <= `FPA_DEF_LINE_RST;
            edit_r <= {SP_W{1'b0}};
            dirty_r <= 1'b0;
            arm_r <= 1'b0;
            flash_msg_r <= `FPA_MSG_NORMAL;
            flash_cnt_r <= 17'h00000;
            idle_cnt_r <= 17'h00000;
            showing_def_r <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                sp_mem[i] <= {SP_W{1'b0}};
            end
        end else begin
            if (is_live(flash_cnt_r) && tick_r) begin
                flash_cnt_r <= flash_cnt_r - 17'h00001;
            end
            if (any_key) begin
                idle_cnt_r <= 17'h00000;
                showing_def_r <= 1'b0;
            end else if (tick_r && !idle_over) begin
                idle_cnt_r <= idle_cnt_r + 17'h00001;
            end
            // A key in the same cycle wins, so a fresh press is never lost
            if (idle_over && !alarm && !trip_r && !showing_def_r && !any_key) begin
                showing_def_r <= 1'b1;
                mode_r <= M_MON;
                page_r <= def_page_r;
                line_r <= def_line_r;
                dirty_r <= 1'b0;
                arm_r <= 1'b0;
            end
            if (any_key && !k_store) begin
                arm_r <= 1'b0;
            end
            if (k_mon) begin
                mode_r <= M_MON;
                page_r <= 2'h0;
                line_r <= 3'h0;
                dirty_r <= 1'b0;
            end else if (k_set) begin
                mode_r <= M_SET;
                page_r <= 2'h0;
                line_r <= 3'h0;
                dirty_r <= 1'b0;
            end else if (k_page) begin
                // Four pages, so the counter wraps from the last to the first
                page_r <= page_r + 2'h1;
                line_r <= 3'h0;
                dirty_r <= 1'b0;
            end else if (k_ldn && line_r != LAST_LINE) begin
                line_r <= line_step(line_r, 1'b1);
                dirty_r <= 1'b0;
            end else if (k_lup && line_r != 3'h0) begin
                line_r <= line_step(line_r, 1'b0);
                dirty_r <= 1'b0;
            end else if ((k_vup || k_vdn) && in_set) begin
                // Edits stay in edit_r; the working setpoint is untouched
                edit_r <= next_sp(shown_sp, k_vup);
                dirty_r <= 1'b1;
            end else if (k_store && in_set) begin
                if (access) begin
                    sp_mem[idx] <= shown_sp;
                    flash_msg_r <= `FPA_MSG_STORED;
                    flash_cnt_r <= CONF_LEN;
                end else begin
                    flash_msg_r <= `FPA_MSG_DENIED;
                    flash_cnt_r <= DENY_LEN;
                end
                // A refused store drops the edit too; it is keyed in again once allowed
                dirty_r <= 1'b0;
            end else if (k_store && in_mon) begin
                // Access input deliberately not consulted here
                if (!arm_r) begin
                    arm_r <= 1'b1;
                end else begin
                    arm_r <= 1'b0;
                    if (page_r != `FPA_PAGE_STATUS) begin
                        def_page_r <= page_r;
                        def_line_r <= line_r;
                        flash_msg_r <= `FPA_MSG_NEWDEF;
                        flash_cnt_r <= CONF_LEN;
                    end
                end
            end
        end
    end

    // Registered panel outputs
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            DISP_MSG_O <= `FPA_MSG_NORMAL;
            DISP_PAGE_O <= 2'h0;
            DISP_LINE_O <= 3'h0;
            DISP_SETTINGS_O <= 1'b0;
            RUN_LED_O <= 1'b0;
            STOP_LED_O <= 1'b0;
            TRIP_LED_O <= 1'b0;
            ALARM_LED_O <= 1'b0;
            SERVICE_LED_O <= 1'b0;
            AUX_OUTPUT_RELAY_O <= 1'b0;
            START_BLOCK_O <= 1'b0;
        end else begin
            if (is_live(flash_cnt_r)) begin
                DISP_MSG_O <= flash_msg_r;
            end else if (showing_def_r) begin
                DISP_MSG_O <= `FPA_MSG_DEFAULT;
            end else begin
                DISP_MSG_O <= `FPA_MSG_NORMAL;
            end
            DISP_PAGE_O <= page_r;
            DISP_LINE_O <= line_r;
            DISP_SETTINGS_O <= in_set;
            // Only contactor command and feedback count; current never reaches here
            RUN_LED_O <= (cmd_a & stat_a) | (cmd_b & stat_b);
            STOP_LED_O <= ~stat_a & ~stat_b;
            TRIP_LED_O <= trip_r;
            START_BLOCK_O <= trip_r;
            ALARM_LED_O <= alarm;
            SERVICE_LED_O <= self_fail;
            case (aux_mode_r)
                `FPA_AUX_TRIP: AUX_OUTPUT_RELAY_O <= trip_r;
                `FPA_AUX_ALARM: AUX_OUTPUT_RELAY_O <= alarm;
                default: AUX_OUTPUT_RELAY_O <= 1'b0;
            endcase
        end
    end

    // Wishbone classic slave: one wait state, ack drops after one cycle
    wire bus_req = CYC_I & STB_I & ~ACK_O;
    wire bus_wr = bus_req & WE_I & SEL_I[0];
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
            aux_mode_r <= `FPA_AUX_OFF;
            ser_rst_r <= 1'b0;
            sp_sel_r <= 5'h00;
        end else begin
            ACK_O <= bus_req;
            ser_rst_r <= 1'b0;
            if (bus_wr && ADR_I == `FPA_ADR_CTRL) begin
                aux_mode_r <= DAT_I[`FPA_CTRL_AUX_HI:`FPA_CTRL_AUX_LO];
                ser_rst_r <= DAT_I[`FPA_CTRL_SER_RST];
            end
            if (bus_wr && ADR_I == `FPA_ADR_SP_SEL) begin
                sp_sel_r <= DAT_I[4:0];
            end
            if (bus_req && !WE_I) begin
                case (ADR_I)
                    `FPA_ADR_CTRL: DAT_O <= {30'h0, aux_mode_r};
                    `FPA_ADR_STATUS: DAT_O <= {14'h0, flash_msg_r, showing_def_r,
                        AUX_OUTPUT_RELAY_O, SERVICE_LED_O, STOP_LED_O, RUN_LED_O,
                        alarm, hard_r, trip_r, line_r, page_r, mode_r};
                    `FPA_ADR_DEFAULT: DAT_O <= {27'h0, def_line_r, def_page_r};
                    `FPA_ADR_SP_SEL: DAT_O <= {27'h0, sp_sel_r};
                    `FPA_ADR_SP_DATA: DAT_O <= {{(32-SP_W){1'b0}}, sp_mem[sp_sel_r]};
                    `FPA_ADR_EDIT: DAT_O <= {{(31-SP_W){1'b0}}, dirty_r, shown_sp};
                    default: DAT_O <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ==== testbench/fpa_top_asserts.sv ====
// Purpose: Port checks for fpa_top.
// Assumes: Level pins are held for eight cycles before their effect is judged.
// Notes: Pin paths carry three cycles of synchroniser and output register latency, four for trip.
`timescale 1ns/100ps
module fpa_top_asserts (
    input wire CLK_I,
    input wire RESET_I,
    input wire CYC_I,
    input wire STB_I,
    input wire ACK_O,
    input wire CMD_A_I,
    input wire CMD_B_I,
    input wire STAT_A_I,
    input wire STAT_B_I,
    input wire TRIP_I,
    input wire ALARM_I,
    input wire SELFTEST_FAIL_I,
    input wire RUN_LED_O,
    input wire STOP_LED_O,
    input wire TRIP_LED_O,
    input wire ALARM_LED_O,
    input wire SERVICE_LED_O,
    input wire AUX_OUTPUT_RELAY_O,
    input wire START_BLOCK_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    wire run_a = CMD_A_I && STAT_A_I;
    wire run_b = CMD_B_I && STAT_B_I;
    a_run_lit: assert property ((run_a || run_b)[*8] |-> RUN_LED_O)
        else $error("run indicator dark");
    a_stop_lit: assert property ((!STAT_A_I && !STAT_B_I)[*8] |-> STOP_LED_O)
        else $error("stop indicator dark");
    a_trip_lit: assert property (TRIP_I[*8] |-> TRIP_LED_O)
        else $error("trip indicator dark");
    a_start_blocked: assert property (START_BLOCK_O == TRIP_LED_O)
        else $error("start block differs from trip");
    a_aux_cause: assert property (AUX_OUTPUT_RELAY_O |-> (TRIP_LED_O || ALARM_LED_O))
        else $error("aux relay without cause");
    a_alarm_lit: assert property (ALARM_I[*8] |-> ALARM_LED_O)
        else $error("alarm indicator dark");
    a_alarm_dark: assert property ((!ALARM_I)[*8] |-> !ALARM_LED_O)
        else $error("alarm indicator stuck");
    a_service_lit: assert property (SELFTEST_FAIL_I[*8] |-> SERVICE_LED_O)
        else $error("service indicator dark");
    a_ack_once: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
        else $error("bus answer late or long");
endmodule

bind fpa_top fpa_top_asserts u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .ACK_O(ACK_O), .CMD_A_I(CMD_A_I), .CMD_B_I(CMD_B_I), .STAT_A_I(STAT_A_I),
    .STAT_B_I(STAT_B_I), .TRIP_I(TRIP_I), .ALARM_I(ALARM_I), .SELFTEST_FAIL_I(SELFTEST_FAIL_I),
    .RUN_LED_O(RUN_LED_O), .STOP_LED_O(STOP_LED_O), .TRIP_LED_O(TRIP_LED_O),
    .ALARM_LED_O(ALARM_LED_O), .SERVICE_LED_O(SERVICE_LED_O),
    .AUX_OUTPUT_RELAY_O(AUX_OUTPUT_RELAY_O), .START_BLOCK_O(START_BLOCK_O));

// ==== testbench/fpa_panel_model.sv ====
// Purpose: Keypad and contactor stand-in for the panel bench.
// Assumes: Presses of one key are at least eight cycles apart.
// Notes: Status lags the command to mimic contactor travel; stuck_i jams it open.
`timescale 1ns/100ps
module fpa_panel_model #(
    parameter LAG = 3
) (
    input wire clk_i,
    input wire [8:0] press_i,
    input wire cmd_a_i,
    input wire cmd_b_i,
    input wire stuck_i,
    output reg [8:0] key_o = 9'h000,
    output wire stat_a_o,
    output wire stat_b_o
);
    reg [8:0] k1_r = 9'h000;
    reg [8:0] k2_r = 9'h000;
    reg [LAG-1:0] a_r = 0;
    reg [LAG-1:0] b_r = 0;
    assign stat_a_o = a_r[LAG-1];
    assign stat_b_o = b_r[LAG-1];
    always @(posedge clk_i) begin
        k1_r <= press_i;
        k2_r <= k1_r;
        // Three-cycle key hold, long enough for the two-stage synchroniser
        key_o <= press_i | k1_r | k2_r;
        a_r <= {a_r[LAG-2:0], cmd_a_i && !stuck_i};
        b_r <= {b_r[LAG-2:0], cmd_b_i && !stuck_i};
    end
endmodule

// ==== testbench/fpa_top_test.sv ====
// Purpose: Self-checking bench for fpa_top.
// Assumes: Short tick and timer parameters; keys come through the panel model.
// Notes: Expected values are worked out here from the panel behaviour.
`timescale 1ns/100ps
module fpa_top_test;
    reg clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] dw = 32'h0, rd;
    reg [8:0] press = 9'h000;
    reg cmd_a = 0, cmd_b = 0, stuck = 0, acc = 0, lrst = 0, trip = 0, tlat = 0;
    reg alarm = 0, fail = 0;
    wire [31:0] dr;
    wire [8:0] keys;
    wire ack, sa, sb, sett, run, stop, tled, aled, sled, aux, sblk;
    wire [2:0] msg, line;
    wire [1:0] page;
    integer bad_count = 0, comparisons = 0, i, n, v;
    always #10 clk = ~clk;
    fpa_top #(.TICK_CYC(4), .IDLE_MS(20), .DENY_MS(8), .CONF_MS(4)) DUT (
        .CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack), .KEY_STORE_I(keys[0]),
        .KEY_PAGE_I(keys[1]), .KEY_LINE_UP_I(keys[2]), .KEY_LINE_DOWN_I(keys[3]),
        .KEY_VALUE_UP_I(keys[4]), .KEY_VALUE_DOWN_I(keys[5]), .KEY_RESET_I(keys[6]),
        .KEY_MONITOR_I(keys[7]), .KEY_SETTINGS_I(keys[8]), .ACCESS_I(acc),
        .LOCKOUT_RESET_I(lrst), .CMD_A_I(cmd_a), .CMD_B_I(cmd_b), .STAT_A_I(sa),
        .STAT_B_I(sb), .TRIP_I(trip), .TRIP_LATCHED_I(tlat), .ALARM_I(alarm),
        .SELFTEST_FAIL_I(fail), .DISP_MSG_O(msg), .DISP_PAGE_O(page), .DISP_LINE_O(line),
        .DISP_SETTINGS_O(sett), .RUN_LED_O(run), .STOP_LED_O(stop), .TRIP_LED_O(tled),
        .ALARM_LED_O(aled), .SERVICE_LED_O(sled), .AUX_OUTPUT_RELAY_O(aux),
        .START_BLOCK_O(sblk));
    fpa_panel_model PM (.clk_i(clk), .press_i(press), .cmd_a_i(cmd_a), .cmd_b_i(cmd_b),
        .stuck_i(stuck), .key_o(keys), .stat_a_o(sa), .stat_b_o(sb));
    function [31:0] def_word(input [1:0] p, input [2:0] l);
        def_word = {27'h0, l, p};
    endfunction
    function [1:0] lamps(input [1:0] c);
        lamps = {|c, ~|c};
    endfunction
    task check(input [31:0] s, input [31:0] e);
        comparisons = comparisons + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task key(input integer k);
        press <= 9'h001 << k;
        @(posedge clk);
        press <= 9'h000;
        repeat (12) @(posedge clk);
    endtask
    task pulse_lockout;
        lrst <= 1'b1;
        repeat (4) @(posedge clk);
        lrst <= 1'b0;
    endtask
    task finish_test;
        $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count = bad_count + 1;
        finish_test;
    end
    initial begin
        void'($urandom(32'h6D35));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        wb(0, 8'h04, 0); check(rd, 32'h801);
        wb(0, 8'h08, 0); check(rd, 32'h4);
        wb(0, 8'h40, 0); check(rd, 32'h0);
        $display("reset test done");
        for (i = 1; i <= 3; i = i + 1) begin
            key(1); check({page, line}, i * 8);
        end
        for (i = 0; i < 8; i = i + 1) key(3);
        check(line, 7);
        key(2); check(line, 6);
        key(3);
        key(1); check({page, line}, 0);
        key(1); key(0); key(0); check(msg, 0);
        wb(0, 8'h08, 0); check(rd, 32'h4);
        key(1);
        n = 1 + $urandom % 7;
        repeat (n) key(3);
        key(0); key(0); check(msg, 2);
        wb(0, 8'h08, 0); check(rd, def_word(2'h2, n[2:0]));
        $display("page and default test done");
        repeat (50) @(posedge clk);
        key(2);
        repeat (20) @(posedge clk); check(msg, 0);
        repeat (150) @(posedge clk);
        check({msg, page, line}, {3'h4, 2'h2, n[2:0]});
        alarm <= 1'b1;
        key(1);
        repeat (150) @(posedge clk);
        check({msg, aled}, 1);
        wb(1, 8'h00, 2); repeat (4) @(posedge clk); check(aux, 1);
        alarm <= 1'b0;
        repeat (10) @(posedge clk); check({aled, aux}, 0);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        wb(0, 8'h08, 0); check(rd, 32'h4);
        $display("idle test done");
        key(8); check({sett, page, line}, 32'h20);
        wb(1, 8'h0C, 0);
        v = 1 + $urandom % 5;
        repeat (v + 1) key(4);
        key(5);
        wb(0, 8'h14, 0); check(rd, 32'h100 | v);
        wb(0, 8'h10, 0); check(rd, 0);
        key(0); check(msg, 3);
        repeat (12) @(posedge clk); check(msg, 3);
        wb(0, 8'h10, 0); check(rd, 0);
        repeat (24) @(posedge clk); check(msg, 0);
        acc <= 1'b1;
        repeat (v) key(4);
        key(0); check(msg, 1);
        wb(0, 8'h10, 0); check(rd, v);
        wb(0, 8'h14, 0); check(rd, v);
        $display("setpoint test done");
        key(7);
        wb(1, 8'h00, 1);
        for (i = 0; i < 3; i = i + 1) begin
            trip <= 1'b1;
            repeat (10) @(posedge clk);
            trip <= 1'b0;
            repeat (6) @(posedge clk); check({tled, sblk, aux}, 7);
            if (i == 0) key(6);
            else if (i == 1) pulse_lockout;
            else wb(1, 8'h00, 5);
            repeat (8) @(posedge clk); check({tled, sblk, aux}, 0);
        end
        tlat <= 1'b1;
        trip <= 1'b1;
        repeat (10) @(posedge clk);
        trip <= 1'b0;
        key(6); check(tled, 1);
        pulse_lockout;
        repeat (8) @(posedge clk); check(tled, 0);
        tlat <= 1'b0;
        $display("trip test done");
        for (i = 0; i < 8; i = i + 1) begin
            n = (i < 4) ? i : $urandom % 4;
            cmd_a <= n[0];
            cmd_b <= n[1];
            repeat (12) @(posedge clk); check({run, stop}, lamps(n[1:0]));
        end
        stuck <= 1'b1;
        cmd_a <= 1'b1;
        cmd_b <= 1'b0;
        repeat (12) @(posedge clk); check({run, stop}, 1);
        fail <= 1'b1;
        repeat (12) @(posedge clk); check(sled, 1);
        $display("indicator test done");
        finish_test;
    end
endmodule
